/* File: rtl/encoder_emulator_pkg.sv */
// Shared widths and reset values for the encoder emulation block.
package encoder_emulator_pkg;
	localparam int POS_W = 16;
	localparam int PPR_W = 16;
	localparam logic [15:0] PPR_RESET = 16'h0400;
	localparam logic [15:0] SHIFT_RESET = 16'h0001;
	localparam logic [15:0] SHIFT_MIN = 16'h0001;
	localparam logic DIR_RESET = 1'b0;
	typedef enum {
		IDLE,
		STEP
	} step_state_t;
endpackage

/* File: rtl/quad_step_if.sv */
// Carries the quarter-step request from the tracker to the quadrature generator.
`timescale 1ns/1ps
interface quad_step_if;
	logic step;
	logic up;
	logic [encoder_emulator_pkg::PPR_W+1:0] count;
	logic [encoder_emulator_pkg::PPR_W+1:0] marker_count;
	modport src (output step, output up, output count, output marker_count);
	modport dst (input step, input up, input count, input marker_count);
endinterface

/* File: rtl/quad_gen.sv */
// Quadrature pattern generator driven by quarter-period steps.
`timescale 1ns/1ps
module quad_gen (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Step requests and phase direction
	quad_step_if.dst         stp,
	input  wire logic        phase_direction,
	// Channels
	output logic             ch_a,
	output logic             ch_b,
	output logic             marker
);
	logic [1:0] phase;
	logic [1:0] next_phase;
	logic       a_raw;
	logic       b_raw;
	logic       next_marker;

	assign next_phase = stp.up ? phase + 2'h1 : phase - 2'h1;
	// Phases 0 to 3 give A,B as 00,10,11,01: A rises first when counting up.
	assign a_raw = next_phase[1] ^ next_phase[0]; // [R7]
	assign b_raw = next_phase[1]; // [R7]
	// Marker is one quarter wide, on the programmed count of the turn.
	assign next_marker = (stp.count == stp.marker_count); // [R10]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 2'h0;
			ch_a <= 1'b0;
			ch_b <= 1'b0;
			marker <= 1'b0;
		end else if (stp.step) begin
			phase <= next_phase;
			ch_a <= phase_direction ? b_raw : a_raw; // [R7] [R8] [R9]
			ch_b <= phase_direction ? a_raw : b_raw; // [R7] [R8] [R9]
			marker <= next_marker; // [R10]
		end
	end
endmodule

/* File: rtl/incremental_encoder_emulator.sv */
// Top of the encoder emulator: position tracking, checks and differential outputs.
`timescale 1ns/1ps
// Functional notes
// [R1] The block outputs quadrature A and B, the marker, and each complement, from the feedback.
// [R2] The operator sets pulses per revolution before the motor starts, not while running.
// [R3] With square-wave feedback a pulse setting unlike the feedback resolution raises a fault.
// [R4] The capture command makes the present shaft angle the marker position.
// [R5] Marker shift runs from 1 to the pulse setting and moves the marker that many pulses; the code moves it one pulse fewer.
// [R6] A marker shift above the pulse setting raises the marker position fault.
// [R7] Direction 0 and clockwise rotation make A lead B by a quarter period.
// [R8] Direction 1 and clockwise rotation make B lead A.
// [R9] Counterclockwise rotation swaps the lead of A and B for either direction.
// [R10] A and B give exactly the programmed periods per turn and one marker per turn.
module incremental_encoder_emulator (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Motor feedback: angle over the full turn, 0 to 2^16-1, clockwise increasing
	input  wire logic [15:0] feedback_position,
	input  wire logic        feedback_is_square,
	input  wire logic [15:0] feedback_resolution,
	// Settings
	input  wire logic [15:0] emul_pulses_per_rev,
	input  wire logic [15:0] emul_marker_shift,
	input  wire logic        emul_phase_direction,
	input  wire logic        marker_capture_command,
	// Differential encoder outputs
	output logic             enc_a,
	output logic             enc_a_n,
	output logic             enc_b,
	output logic             enc_b_n,
	output logic             reference_marker,
	output logic             reference_marker_n,
	// Faults
	output logic             marker_position_error,
	output logic             pulse_count_mismatch_error
);
	localparam int CW = encoder_emulator_pkg::PPR_W + 2;

	//////////////////////////////////////////////////////////////////////////////
	// Input synchronisers.
	// Every setting passes two flops. A word caught mid-change is off for one cycle only,
	// which is harmless because settings are expected to change with the motor at rest.
	logic [15:0] pos_s1;
	logic [15:0] pos_s2;
	logic        cap_s1;
	logic        cap_s2;
	logic        cap_d;
	logic        sq_s1;
	logic        sq_s2;
	logic [15:0] res_s1;
	logic [15:0] res_s2;
	logic [15:0] ppr_s1;
	logic [15:0] ppr_s2;
	logic [15:0] shf_s1;
	logic [15:0] shf_s2;
	logic        dir_s1;
	logic        dir_s2;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos_s1 <= 16'h0000;
			pos_s2 <= 16'h0000;
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_d <= 1'b0;
			sq_s1 <= 1'b0;
			sq_s2 <= 1'b0;
			res_s1 <= 16'h0000;
			res_s2 <= 16'h0000;
			ppr_s1 <= encoder_emulator_pkg::PPR_RESET;
			ppr_s2 <= encoder_emulator_pkg::PPR_RESET;
			shf_s1 <= encoder_emulator_pkg::SHIFT_RESET;
			shf_s2 <= encoder_emulator_pkg::SHIFT_RESET;
			dir_s1 <= encoder_emulator_pkg::DIR_RESET;
			dir_s2 <= encoder_emulator_pkg::DIR_RESET;
		end else begin
			pos_s1 <= feedback_position;
			pos_s2 <= pos_s1;
			cap_s1 <= marker_capture_command;
			cap_s2 <= cap_s1;
			cap_d <= cap_s2;
			sq_s1 <= feedback_is_square;
			sq_s2 <= sq_s1;
			res_s1 <= feedback_resolution;
			res_s2 <= res_s1;
			ppr_s1 <= emul_pulses_per_rev;
			ppr_s2 <= ppr_s1;
			shf_s1 <= emul_marker_shift;
			shf_s2 <= shf_s1;
			dir_s1 <= emul_phase_direction;
			dir_s2 <= dir_s1;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Target edge count: angle * 4 * ppr / 2^16, in quarter periods per turn.
	// The product needs 34 bits; its upper 18 bits are the whole quarters.
	function automatic logic [CW-1:0] quarters(input logic [15:0] ang, input logic [15:0] ppr);
		logic [33:0] prod;
		prod = {18'h00000, ang} * {16'h0000, ppr, 2'h0};
		return prod[CW+15:16];
	endfunction

	// One quarter forward or back, wrapping at the ends of the turn.
	function automatic logic [CW-1:0] step_once(input logic [CW-1:0] cur,
		input logic [CW-1:0] turn, input logic up);
		logic [CW-1:0] last;
		last = turn - 1'b1;
		if (up)
			return (cur >= last) ? '0 : cur + 1'b1;
		else
			return (cur == '0) ? last : cur - 1'b1;
	endfunction

	logic [CW-1:0] edges_per_turn;
	logic [CW-1:0] target;
	logic [CW-1:0] count;
	logic [CW-1:0] origin;
	logic [CW-1:0] marker_count;
	logic [CW-1:0] shift_edges;
	logic [CW-1:0] sum_marker;
	logic          need_up;
	logic          need_down;
	logic          moving;
	logic          shift_too_big;
	logic          count_mismatch;
	logic          capture_pulse;
	encoder_emulator_pkg::step_state_t state;
	encoder_emulator_pkg::step_state_t next_state;

	assign edges_per_turn = {ppr_s2, 2'h0}; // [R10]
	assign target = quarters(pos_s2, ppr_s2); // [R1]
	assign capture_pulse = cap_s2 & ~cap_d;
	// Shift of N pulses places the marker (N-1)*4 quarters past the origin.
	assign shift_edges = {shf_s2 - encoder_emulator_pkg::SHIFT_MIN, 2'h0}; // [R5]
	assign sum_marker = origin + shift_edges; // [R5]
	// One subtraction wraps any legal shift. A shift far above the pulse count can land
	// outside the turn, and then no marker is issued; the position fault flags that case.
	assign marker_count = (sum_marker >= edges_per_turn) ?
		sum_marker - edges_per_turn : sum_marker;
	// The count follows the target one quarter at a time, taking the short way round.
	// A step takes two cycles, so positions moving faster than one quarter per 200 ns
	// leave the outputs trailing until the shaft slows down.
	assign need_up = (target != count) &&
		((target > count) ? (target - count) <= (edges_per_turn >> 1)
			: (count - target) > (edges_per_turn >> 1));
	assign need_down = (target != count) && !need_up;
	assign moving = need_up || need_down;

	quad_step_if stp ();
	assign stp.up = need_up;
	assign stp.step = (state == encoder_emulator_pkg::STEP);
	assign stp.count = step_once(count, edges_per_turn, need_up); // [R10]
	assign stp.marker_count = marker_count;

	//////////////////////////////////////////////////////////////////////////////
	// Step sequencer: one quarter step, then one idle cycle so the way is judged anew.
	always_comb begin
		case (state)
			encoder_emulator_pkg::IDLE: next_state =
				moving ? encoder_emulator_pkg::STEP : encoder_emulator_pkg::IDLE;
			encoder_emulator_pkg::STEP: next_state = encoder_emulator_pkg::IDLE;
			default: next_state = encoder_emulator_pkg::IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= encoder_emulator_pkg::IDLE;
			count <= '0;
			origin <= '0;
		end else begin
			state <= next_state;
			if (stp.step)
				count <= stp.count; // [R10]
			// The count, not the raw angle, is taken so the marker falls on a whole quarter.
			if (capture_pulse)
				origin <= count; // [R4]
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Setting faults. They follow the settings and are not latched.
	assign shift_too_big = shf_s2 > ppr_s2; // [R6]
	assign count_mismatch = sq_s2 && (ppr_s2 != res_s2); // [R3]

	//////////////////////////////////////////////////////////////////////////////
	// Quadrature generator and outputs.
	logic qa;
	logic qb;
	logic qm;

	quad_gen gen (
		.clk             (clk),
		.rst             (rst),
		.stp             (stp),
		.phase_direction (dir_s2),
		.ch_a            (qa),
		.ch_b            (qb),
		.marker          (qm)
	);

	// A second register stage keeps every pin glitch-free and switches each line
	// together with its complement on the same edge.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enc_a <= 1'b0;
			enc_a_n <= 1'b1;
			enc_b <= 1'b0;
			enc_b_n <= 1'b1;
			reference_marker <= 1'b0;
			reference_marker_n <= 1'b1;
			marker_position_error <= 1'b0;
			pulse_count_mismatch_error <= 1'b0;
		end else begin
			enc_a <= qa; // [R1]
			enc_a_n <= ~qa; // [R1]
			enc_b <= qb; // [R1]
			enc_b_n <= ~qb; // [R1]
			reference_marker <= qm; // [R1]
			reference_marker_n <= ~qm; // [R1]
			marker_position_error <= shift_too_big; // [R6]
			pulse_count_mismatch_error <= count_mismatch; // [R3]
		end
	end
endmodule

/* File: dv/encoder_emulator_properties.sv */
// Port-level assertions of the encoder emulator.
`timescale 1ns/1ps
module encoder_emulator_properties (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Settings
	input wire logic        feedback_is_square,
	input wire logic [15:0] feedback_resolution,
	input wire logic [15:0] emul_pulses_per_rev,
	input wire logic [15:0] emul_marker_shift,
	// Outputs
	input wire logic        enc_a,
	input wire logic        enc_a_n,
	input wire logic        enc_b,
	input wire logic        enc_b_n,
	input wire logic        reference_marker,
	input wire logic        reference_marker_n,
	input wire logic        marker_position_error,
	input wire logic        pulse_count_mismatch_error
);
	// Five samples cover both synchroniser stages and the fault register.
	wire logic sb = emul_marker_shift > emul_pulses_per_rev;
	wire logic cb = feedback_is_square && feedback_resolution != emul_pulses_per_rev;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_a_pair: assert property (enc_a_n != enc_a) else $error("A pair");
	chk_b_pair: assert property (enc_b_n != enc_b) else $error("B pair");
	chk_mark_pair: assert property (reference_marker_n != reference_marker)
		else $error("marker pair");
	chk_shift_high: assert property (sb [*5] |-> marker_position_error)
		else $error("shift fault missing");
	chk_shift_ok: assert property ((!sb) [*5] |-> !marker_position_error)
		else $error("shift fault spurious");
	chk_count_bad: assert property (cb [*5] |-> pulse_count_mismatch_error)
		else $error("count fault missing");
	chk_count_ok: assert property ((!cb) [*5] |-> !pulse_count_mismatch_error)
		else $error("count fault spurious");
	chk_gray_step: assert property (!($changed(enc_a) && $changed(enc_b)))
		else $error("both channels moved");
endmodule
bind incremental_encoder_emulator encoder_emulator_properties chk_u (.clk(clk), .rst(rst),
	.feedback_is_square(feedback_is_square), .feedback_resolution(feedback_resolution),
	.emul_pulses_per_rev(emul_pulses_per_rev), .emul_marker_shift(emul_marker_shift),
	.enc_a(enc_a), .enc_a_n(enc_a_n), .enc_b(enc_b), .enc_b_n(enc_b_n),
	.reference_marker(reference_marker), .reference_marker_n(reference_marker_n),
	.marker_position_error(marker_position_error),
	.pulse_count_mismatch_error(pulse_count_mismatch_error));

/* File: dv/quad_counter_model.sv */
// Quadrature counter of the motion controller facing the emulated encoder.
`timescale 1ns/1ps
module quad_counter_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Encoder lines
	input  wire logic a,
	input  wire logic b,
	input  wire logic z,
	// Counts
	output int        count,
	output int        marks
);
	// Phase index 0..3 along the A-leads sequence; a jump of two is ignored as noise.
	wire  logic [1:0] ph = {b, a ^ b};
	logic [1:0]       ph_q;
	logic             z_q;
	wire  logic [1:0] st = ph - ph_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{count, marks, ph_q, z_q} <= '0;
		end else begin
			ph_q  <= ph;
			z_q   <= z;
			count <= count + (st == 2'h1) - (st == 2'h3);
			marks <= marks + (z && !z_q);
		end
	end
endmodule

/* File: dv/tb_top.sv */
// Encoder emulator bench: whole turns counted by the controller model.
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic [15:0] ppr, sh, res; logic sq, dir, cw; logic [1:0] er;} row_t;
	// Each row is one whole turn back to angle zero, so a new pulse count makes no jump.
	row_t        rows [4] = '{'{16'h0010, 16'h0001, 16'h0010, 1'h1, 1'h0, 1'h1, 2'h0},
		'{16'h0010, 16'h0010, 16'h0000, 1'h0, 1'h1, 1'h1, 2'h0},
		'{16'h0010, 16'h0011, 16'h000F, 1'h1, 1'h0, 1'h0, 2'h3},
		'{16'h0008, 16'h0003, 16'h0008, 1'h1, 1'h1, 1'h0, 2'h0}};
	logic        clk, rst, sq, dir, cap, a, an, b, bn, mk, mkn, ep, ec;
	logic [15:0] pos, res, ppr, sh;
	int          cnt, mks, c0, m0, n_fail, samples_checked, cyc;
	incremental_encoder_emulator dut_u (.clk(clk), .rst(rst), .feedback_position(pos),
		.feedback_is_square(sq), .feedback_resolution(res), .emul_pulses_per_rev(ppr),
		.emul_marker_shift(sh), .emul_phase_direction(dir), .marker_capture_command(cap),
		.enc_a(a), .enc_a_n(an), .enc_b(b), .enc_b_n(bn), .reference_marker(mk),
		.reference_marker_n(mkn), .marker_position_error(ep), .pulse_count_mismatch_error(ec));
	quad_counter_model ctl_u (.clk(clk), .rst(rst), .a(a), .b(b), .z(mk),
		.count(cnt), .marks(mks));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Steps stay well under one quarter per two cycles so the outputs never lag behind.
	task automatic move(input int n, input logic cw);
		repeat (n) @(posedge clk) pos <= cw ? pos + 16'h0040 : pos - 16'h0040;
		repeat (40) @(posedge clk);
	endtask
	task automatic close_out();
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		{rst, sq, dir, cap, pos, res, ppr, sh} = {4'h8, 32'h0, 16'h0010, 16'h0001};
		repeat (4) @(posedge clk);
		chk({a, b, mk, ep, ec, an, bn, mkn}, 32'h07);
		rst <= 1'h0;
		foreach (rows[i]) begin
			{ppr, sh, res, sq, dir} <= rows[i][52:3];
			repeat (10) @(posedge clk);
			{c0, m0} = {cnt, mks};
			move(1024, rows[i].cw);
			chk(cnt - c0, (rows[i].cw ^ rows[i].dir) ? 4 * ppr : -4 * ppr);
			chk(mks - m0, 1);
			chk({ep, ec}, rows[i].er);
		end
		// Marker only moves on a quarter step, so each check enters the quarter by moving.
		{ppr, sh, sq} <= {16'h0010, 16'h0001, 1'h0};
		move(256, 1'h1);
		chk(mk, 0);
		cap <= 1'h1;
		move(16, 1'h1);
		chk(mk, 0);
		move(16, 1'h0);
		chk(mk, 1);
		move(16, 1'h1);
		chk(mk, 0);
		{cap, sh} <= {1'h0, 16'h0002};
		move(48, 1'h1);
		chk(mk, 1);
		close_out();
	end
endmodule
